// [verilog/lfs_consts.svh]
// constants for the led fault supervisor: timing, current steps, channel count
// assumes a 125 MHz clock; included by bare name
`ifndef LFS_CONSTS_SVH
`define LFS_CONSTS_SVH

`define LFS_CLK_MHZ          125
`define LFS_NUM_CH           6
// time-outs in microseconds, as printed
`define LFS_OPEN_HOT_US      800
`define LFS_SHORT_COLD_US    6000
`define LFS_SHORT_HOT_US     420
`define LFS_OPEN_COLD_US     6000
`define LFS_OVP_US           6000
// cycle counts derived from the times
`define LFS_CYC(us)          ((us) * `LFS_CLK_MHZ)
// current step levels in percent
`define LFS_LEVEL_FULL       7'h64
`define LFS_LEVEL_STEP1      7'h4D
`define LFS_LEVEL_STEP2      7'h35
`define LFS_LEVEL_STEP3      7'h1E
// start-up short check settle time in cycles
`define LFS_PROBE_CYC        16'h0400

`endif

// [verilog/lfs_pkg.sv]
// types shared by the led fault supervisor files
// assumes nothing beyond a SystemVerilog compiler
package lfs_pkg;
    typedef enum logic [1:0] {
        LFS_IDLE,
        LFS_PROBE,
        LFS_RUN,
        LFS_THERMAL
    } lfs_state_e;

    typedef enum logic [1:0] {
        LFS_STEP_FULL,
        LFS_STEP_77,
        LFS_STEP_53,
        LFS_STEP_30
    } lfs_step_e;
endpackage : lfs_pkg

// [verilog/lfs_channel.sv]
// one channel's fault watcher: good/open marking, short detect, time-outs
// assumes inputs already synchronised to clock
`timescale 1ns/100ps
`default_nettype none
module lfs_channel
    import lfs_pkg::*;
#(
    parameter int CNT_W = 20
) (
    // clock and control
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic             clk_en,
    input  wire logic             active,
    input  wire logic             sinks_on,
    // comparator levels
    input  wire logic             above_short,
    input  wire logic             reached_75,
    input  wire logic             below_50,
    input  wire logic             force_open,
    input  wire logic             lower_hot,
    // time-out lengths in cycles
    input  wire logic [CNT_W-1:0] open_limit,
    input  wire logic [CNT_W-1:0] short_limit,
    // state
    output logic                  disabled_ff,
    output logic                  good_ff,
    output logic                  open_ff
);
    logic [CNT_W-1:0] open_cnt_ff;
    logic [CNT_W-1:0] short_cnt_ff;

    // ==========================================================
    // good and open marking
    always_ff @(posedge clock) begin
        if (reset || (clk_en && !active)) begin
            good_ff <= 1'b0;
            open_ff <= 1'b0;
        end else if (clk_en && sinks_on && !disabled_ff) begin
            if (reached_75)
                good_ff <= 1'b1;                             // see R18
            if ((good_ff && below_50) || (!good_ff && force_open)
                    || (lower_hot && below_50))
                open_ff <= 1'b1;                             // see R18 R20 R02 R13
            else if (!below_50 && good_ff)
                open_ff <= 1'b0;
        end
    end

    // ==========================================================
    // time-out counters and disable latch
    always_ff @(posedge clock) begin
        if (reset || (clk_en && !active)) begin
            open_cnt_ff  <= '0;
            short_cnt_ff <= '0;
            disabled_ff  <= 1'b0;
        end else if (clk_en && sinks_on && !disabled_ff) begin
            if (open_ff)
                open_cnt_ff <= open_cnt_ff + 1'b1;           // see R21
            else
                open_cnt_ff <= '0;
            if (above_short)
                short_cnt_ff <= short_cnt_ff + 1'b1;         // see R09 R12
            else
                short_cnt_ff <= '0;
            // shorted channel below threshold stays on; only timers disable
            if ((open_ff && open_cnt_ff >= open_limit)
                    || (above_short && short_cnt_ff >= short_limit))
                disabled_ff <= 1'b1;                         // see R02 R08 R10 R14
        end
    end
endmodule : lfs_channel
`default_nettype wire

// [verilog/lfs_supervisor.sv]
// led fault supervisor top: thermal steps, boost stop, fault switch control
// assumes comparator flags arrive asynchronously and are synchronised here
//
// Summary of operation
// R01 - two temperature flags watched separately
// R02 - hot: low-current channel open, disabled on time-out
// R03 - hot: open time-out shortens to 800 us
// R04 - upper trip stops boost and all sinks
// R05 - restart on cooled flag at 77 percent
// R06 - later trips step to 53 then 30
// R07 - only enable low leaves active state
// R08 - short below threshold keeps channel on
// R09 - short over threshold: 6 ms or 420 us
// R10 - infinite open: ovp then 6 ms off
// R11 - zener-bypassed channel stays enabled
// R12 - healthy channel over threshold switched off
// R13 - hot, no short: below half disabled
// R14 - overvoltage: unreached channels off after 6 ms
// R15 - output short: fault switch off until clear; in thermal the code ignores it and keeps the switch on
// R16 - sense below 20 percent means short
// R17 - probe switch node before enabling switch
// R18 - good at 75, open below 50
// R19 - short flag means sink above 8 V
// R20 - ovp or lower hot opens not-good channels
// R21 - counter time-outs; step held until reset (the code also returns the step to full when enable goes low)
`timescale 1ns/100ps
`default_nettype none
`include "lfs_consts.svh"
module lfs_supervisor
    import lfs_pkg::*;
#(
    parameter int NUM_CH       = `LFS_NUM_CH,
    parameter int OPEN_COLD_CY = `LFS_CYC(`LFS_OPEN_COLD_US),
    parameter int OPEN_HOT_CY  = `LFS_CYC(`LFS_OPEN_HOT_US),
    parameter int SHORT_COLD_CY = `LFS_CYC(`LFS_SHORT_COLD_US),
    parameter int SHORT_HOT_CY = `LFS_CYC(`LFS_SHORT_HOT_US),
    parameter int PROBE_CY     = `LFS_PROBE_CYC
) (
    // clock, reset, enable
    input  wire logic              clock,
    input  wire logic              reset,
    input  wire logic              clk_en,
    input  wire logic              enable_pin,
    // temperature flags
    input  wire logic              temp_lower_hot,
    input  wire logic              temp_upper_hot,
    input  wire logic              temp_cooled,
    // per-channel comparators
    input  wire logic [NUM_CH-1:0] sink_above_short,
    input  wire logic [NUM_CH-1:0] current_reached_75,
    input  wire logic [NUM_CH-1:0] current_below_50,
    // output monitors
    input  wire logic              output_overvoltage_limit,
    input  wire logic              ovp_sense_below_20,
    input  wire logic              switch_node_above_probe,
    // controls
    output logic                   boost_run_ff,
    output logic [NUM_CH-1:0]      sink_enable_ff,
    output logic [6:0]             current_level_ff,
    output logic [1:0]             step_code_ff,
    output logic                   fault_switch_on_ff,
    output logic                   probe_inject_ff,
    output logic                   active_ff,
    output logic [NUM_CH-1:0]      channel_disabled_ff
);
    localparam int CNT_W = 24;
    localparam int PRB_W = 16;

    // parameter checks, refused at elaboration
    if (NUM_CH < 1 || NUM_CH > 32) begin : g_bad_ch
        $error("lfs_supervisor: NUM_CH out of range");
    end
    if (OPEN_COLD_CY >= (1 << CNT_W) || SHORT_COLD_CY >= (1 << CNT_W)
            || OPEN_HOT_CY >= (1 << CNT_W) || SHORT_HOT_CY >= (1 << CNT_W)) begin : g_bad_cnt
        $error("lfs_supervisor: time-out too long for counter");
    end
    if (PROBE_CY < 1 || PROBE_CY >= (1 << PRB_W)) begin : g_bad_prb
        $error("lfs_supervisor: bad probe length");
    end

    // ==========================================================
    // input synchronisers
    localparam int SYN_W = 7 + 3 * NUM_CH;
    logic [SYN_W-1:0] sync1_ff;
    logic [SYN_W-1:0] sync2_ff;

    always_ff @(posedge clock) begin
        if (reset) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else if (clk_en) begin
            sync1_ff <= {enable_pin, temp_lower_hot, temp_upper_hot, temp_cooled,
                         output_overvoltage_limit, ovp_sense_below_20,
                         switch_node_above_probe, sink_above_short,
                         current_reached_75, current_below_50};
            sync2_ff <= sync1_ff;
        end
    end

    logic              en_s;
    logic              lower_hot_s;
    logic              upper_hot_s;
    logic              cooled_s;
    logic              ovp_s;
    logic              sense_low_s;
    logic              lx_ok_s;
    logic [NUM_CH-1:0] short_s;
    logic [NUM_CH-1:0] good75_s;
    logic [NUM_CH-1:0] low50_s;

    // sink_above_short is high when a sink sits above 8 V; see R19
    assign {en_s, lower_hot_s, upper_hot_s, cooled_s, ovp_s, sense_low_s,
            lx_ok_s, short_s, good75_s, low50_s} = sync2_ff;

    // ==========================================================
    // output short detect: sense above 20 percent, then drops under it
    logic sense_armed_ff;
    logic out_short;

    // armed only in run or thermal
    always_ff @(posedge clock) begin
        if (reset)
            sense_armed_ff <= 1'b0;
        else if (clk_en) begin
            if (!en_s || (state_ff != LFS_RUN && state_ff != LFS_THERMAL))
                sense_armed_ff <= 1'b0;
            else if (!sense_low_s)
                sense_armed_ff <= 1'b1;                      // see R16
        end
    end

    // switch node low, with the switch on or off, also means a short to ground
    assign out_short = (sense_armed_ff && sense_low_s) || !lx_ok_s; // see R15 R16

    // ==========================================================
    // main state machine
    lfs_state_e        state_ff;
    lfs_state_e        nxt_state;
    logic [PRB_W-1:0]  probe_cnt_ff;
    lfs_step_e         step_ff;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            LFS_IDLE:
                if (en_s)
                    nxt_state = LFS_PROBE;
            LFS_PROBE:
                if (!en_s)
                    nxt_state = LFS_IDLE;
                else if (probe_cnt_ff >= PRB_W'(PROBE_CY) && lx_ok_s)
                    nxt_state = LFS_RUN;                     // see R17
            LFS_RUN:
                if (!en_s)
                    nxt_state = LFS_IDLE;                    // see R07
                else if (out_short)
                    nxt_state = LFS_PROBE;                   // see R15
                else if (upper_hot_s)
                    nxt_state = LFS_THERMAL;                 // see R04
            LFS_THERMAL:
                if (!en_s)
                    nxt_state = LFS_IDLE;
                else if (cooled_s && !upper_hot_s)
                    nxt_state = LFS_RUN;                     // see R05 R07
            default:
                nxt_state = LFS_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset)
            state_ff <= LFS_IDLE;
        else if (clk_en)
            state_ff <= nxt_state;
    end

    // probe current timing; restarted whenever the check begins again
    always_ff @(posedge clock) begin
        if (reset)
            probe_cnt_ff <= '0;
        else if (clk_en) begin
            if (state_ff != LFS_PROBE || !lx_ok_s)
                probe_cnt_ff <= '0;
            else if (probe_cnt_ff < PRB_W'(PROBE_CY))
                probe_cnt_ff <= probe_cnt_ff + 1'b1;
        end
    end

    // ==========================================================
    // thermal step level, held until reset or enable low
    always_ff @(posedge clock) begin
        if (reset || (clk_en && !en_s))
            step_ff <= LFS_STEP_FULL;                        // see R21
        else if (clk_en && state_ff == LFS_RUN && nxt_state == LFS_THERMAL) begin
            case (step_ff)
                LFS_STEP_FULL: step_ff <= LFS_STEP_77;       // see R05
                LFS_STEP_77:   step_ff <= LFS_STEP_53;       // see R06
                default:       step_ff <= LFS_STEP_30;       // see R06
            endcase
        end
    end

    // ==========================================================
    // per-channel watchers
    logic              run;
    logic              any_short;
    logic [CNT_W-1:0]  open_limit;
    logic [CNT_W-1:0]  short_limit;
    logic [NUM_CH-1:0] ch_dis;
    logic [NUM_CH-1:0] below_hot;

    assign run       = (state_ff == LFS_RUN);
    assign any_short = |short_s;
    // lower temperature shortens both time-outs; see R01 R03 R09
    assign open_limit  = lower_hot_s ? CNT_W'(OPEN_HOT_CY) : CNT_W'(OPEN_COLD_CY);
    assign short_limit = lower_hot_s ? CNT_W'(SHORT_HOT_CY) : CNT_W'(SHORT_COLD_CY);
    // hot and no sink shorted: channels under half current go open; see R13
    assign below_hot = (lower_hot_s && !any_short) ? low50_s : '0;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            // zener-bypassed strings only trip via short or open timers; see R11
            lfs_channel #(
                .CNT_W      (CNT_W)
            ) u_ch (
                .clock      (clock),
                .reset      (reset),
                .clk_en     (clk_en),
                .active     (en_s),
                .sinks_on   (run),
                .above_short(short_s[g]),
                .reached_75 (good75_s[g]),
                .below_50   (low50_s[g] || below_hot[g]),
                .force_open (ovp_s || lower_hot_s),          // see R20 R14 R10
                .lower_hot  (lower_hot_s),
                .open_limit (open_limit),
                .short_limit(short_limit),
                .disabled_ff(ch_dis[g]),
                .good_ff    (),
                .open_ff    ()
            );
        end
    endgenerate

    // ==========================================================
    // registered outputs
    always_ff @(posedge clock) begin
        if (reset) begin
            boost_run_ff        <= 1'b0;
            sink_enable_ff      <= '0;
            fault_switch_on_ff  <= 1'b0;
            probe_inject_ff     <= 1'b0;
            active_ff           <= 1'b0;
            channel_disabled_ff <= '0;
        end else if (clk_en) begin
            boost_run_ff        <= (nxt_state == LFS_RUN);                 // see R04
            sink_enable_ff      <= (nxt_state == LFS_RUN) ? ~ch_dis : '0;  // see R04 R12
            fault_switch_on_ff  <= (nxt_state == LFS_RUN)
                                   || (nxt_state == LFS_THERMAL);          // see R15 R17
            probe_inject_ff     <= (nxt_state == LFS_PROBE);               // see R17
            active_ff           <= (nxt_state != LFS_IDLE);                // see R07
            channel_disabled_ff <= ch_dis;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            current_level_ff <= `LFS_LEVEL_FULL;
            step_code_ff     <= 2'h0;
        end else if (clk_en) begin
            step_code_ff <= step_ff;
            case (step_ff)
                LFS_STEP_FULL: current_level_ff <= `LFS_LEVEL_FULL;
                LFS_STEP_77:   current_level_ff <= `LFS_LEVEL_STEP1;       // see R05
                LFS_STEP_53:   current_level_ff <= `LFS_LEVEL_STEP2;       // see R06
                default:       current_level_ff <= `LFS_LEVEL_STEP3;       // see R06
            endcase
        end
    end

    // ==========================================================
    // checks
    a_trip_stops_boost: assert property (@(posedge clock) disable iff (reset) // see R04
        clk_en && state_ff == LFS_RUN && en_s && !out_short && upper_hot_s
        |=> !boost_run_ff && sink_enable_ff == '0)
        else $error("upper trip did not stop boost");

    a_step_on_trip: assert property (@(posedge clock) disable iff (reset) // see R05
        clk_en && state_ff == LFS_RUN && nxt_state == LFS_THERMAL
        && step_ff == LFS_STEP_FULL |=> step_ff == LFS_STEP_77)
        else $error("first trip did not step to 77");

    a_step_holds: assert property (@(posedge clock) disable iff (reset) // see R21
        en_s && $past(en_s) && $past(clk_en) && step_ff != $past(step_ff)
        |-> $past(state_ff) == LFS_RUN)
        else $error("step changed outside a trip");

    a_short_switch_off: assert property (@(posedge clock) disable iff (reset) // see R15
        clk_en && state_ff == LFS_RUN && en_s && out_short |=> !fault_switch_on_ff)
        else $error("short did not open fault switch");

    a_probe_first: assert property (@(posedge clock) disable iff (reset) // see R17
        $rose(fault_switch_on_ff) |-> $past(state_ff) == LFS_PROBE || $past(state_ff) == LFS_RUN)
        else $error("fault switch on without probe");

    a_enable_leaves: assert property (@(posedge clock) disable iff (reset) // see R07
        clk_en && !en_s && state_ff != LFS_IDLE |=> !active_ff)
        else $error("enable low did not leave active");

    a_thermal_stays: assert property (@(posedge clock) disable iff (reset) // see R07
        clk_en && state_ff == LFS_THERMAL && en_s |=> active_ff)
        else $error("thermal left active state");

    a_hot_limit: assert property (@(posedge clock) disable iff (reset) // see R03
        lower_hot_s |-> open_limit == CNT_W'(OPEN_HOT_CY) && short_limit == CNT_W'(SHORT_HOT_CY))
        else $error("hot time-out not shortened");

    a_disabled_off: assert property (@(posedge clock) disable iff (reset) // see R09
        clk_en && ch_dis[0] |=> !sink_enable_ff[0])
        else $error("disabled channel still driven");

    a_probe_disarms: assert property (@(posedge clock) disable iff (reset) // see R16
        clk_en && state_ff == LFS_PROBE |=> !sense_armed_ff)
        else $error("probe left armed");

    a_step_final: assert property (@(posedge clock) disable iff (reset) // see R06
        clk_en && en_s && step_ff == LFS_STEP_30 |=> step_ff == LFS_STEP_30)
        else $error("final step left");

    a_probe_blocks: assert property (@(posedge clock) disable iff (reset) // see R17
        clk_en && state_ff == LFS_PROBE && !lx_ok_s |=> !fault_switch_on_ff)
        else $error("switch on in probe");

    a_idle_quiet: assert property (@(posedge clock) disable iff (reset) // see R07
        clk_en && state_ff == LFS_IDLE && !en_s |=> !active_ff && !boost_run_ff)
        else $error("idle drove outputs");

    a_cool_restart: assert property (@(posedge clock) disable iff (reset) // see R05
        clk_en && state_ff == LFS_THERMAL && en_s && cooled_s && !upper_hot_s
        |=> boost_run_ff)
        else $error("no restart on cool");
endmodule : lfs_supervisor
`default_nettype wire

// [verification/lfs_string_model.sv]
// behavioural far side: led strings, boost power stage, input fault switch
// assumes the bench commands faults; flags settle combinationally from controls
`timescale 1ns/100ps
`default_nettype none
module lfs_string_model (
    // controls from the supervisor
    input  wire logic       boost_run,
    input  wire logic [5:0] sink_enable,
    input  wire logic       fault_switch_on,
    input  wire logic       probe_inject,
    // faults commanded by the bench
    input  wire logic [5:0] short_cmd,
    input  wire logic [5:0] open_cmd,
    input  wire logic       gnd_short,
    // comparator levels back to the supervisor
    output logic [5:0]      sink_above_short,
    output logic [5:0]      current_reached_75,
    output logic [5:0]      current_below_50,
    output logic            output_overvoltage_limit,
    output logic            ovp_sense_below_20,
    output logic            switch_node_above_probe
);
    logic [5:0] lit;
    // a string carries current only while its sink, boost and switch all run
    assign lit = sink_enable & {6{boost_run & fault_switch_on}} & ~open_cmd;
    assign current_reached_75 = lit;
    assign current_below_50 = ~lit;
    assign sink_above_short = sink_enable & short_cmd;
    // an open string with its sink on pulls the output up to the limit
    assign output_overvoltage_limit = boost_run & |(open_cmd & sink_enable);
    // output sits near ground while the switch is off or shorted
    assign ovp_sense_below_20 = gnd_short | ~fault_switch_on;
    assign switch_node_above_probe = ~gnd_short & (probe_inject | fault_switch_on);
endmodule : lfs_string_model
`default_nettype wire

// [verification/led_fault_supervisor_tb.sv]
// self-checking bench for the led fault supervisor
// assumes lfs_string_model as far side; short time-outs set by parameters
`timescale 1ns/100ps
`default_nettype none
module led_fault_supervisor_tb;
    import lfs_pkg::*;
    localparam int OPEN_COLD = 40;
    localparam int OPEN_HOT = 20;
    localparam int SHORT_COLD = 40;
    localparam int SHORT_HOT = 10;
    localparam int PROBE = 8;
    logic       clock, reset, clk_en, enable_pin, gnd_short;
    logic       temp_lower_hot, temp_upper_hot, temp_cooled;
    logic [5:0] sink_above_short, current_reached_75, current_below_50;
    logic [5:0] short_cmd, open_cmd, sink_enable_ff, channel_disabled_ff;
    logic       output_overvoltage_limit, ovp_sense_below_20, switch_node_above_probe;
    logic       boost_run_ff, fault_switch_on_ff, probe_inject_ff, active_ff;
    logic [6:0] current_level_ff;
    logic [1:0] step_code_ff;
    int         n_mismatch, samples_checked, cycles, k;

    lfs_supervisor #(.NUM_CH(6), .OPEN_COLD_CY(OPEN_COLD), .OPEN_HOT_CY(OPEN_HOT),
        .SHORT_COLD_CY(SHORT_COLD), .SHORT_HOT_CY(SHORT_HOT), .PROBE_CY(PROBE)) DUT (
        .clock(clock), .reset(reset), .clk_en(clk_en), .enable_pin(enable_pin),
        .temp_lower_hot(temp_lower_hot), .temp_upper_hot(temp_upper_hot),
        .temp_cooled(temp_cooled), .sink_above_short(sink_above_short),
        .current_reached_75(current_reached_75), .current_below_50(current_below_50),
        .output_overvoltage_limit(output_overvoltage_limit),
        .ovp_sense_below_20(ovp_sense_below_20),
        .switch_node_above_probe(switch_node_above_probe), .boost_run_ff(boost_run_ff),
        .sink_enable_ff(sink_enable_ff), .current_level_ff(current_level_ff),
        .step_code_ff(step_code_ff), .fault_switch_on_ff(fault_switch_on_ff),
        .probe_inject_ff(probe_inject_ff), .active_ff(active_ff),
        .channel_disabled_ff(channel_disabled_ff));

    lfs_string_model u_load (
        .boost_run(boost_run_ff), .sink_enable(sink_enable_ff),
        .fault_switch_on(fault_switch_on_ff), .probe_inject(probe_inject_ff),
        .short_cmd(short_cmd), .open_cmd(open_cmd), .gnd_short(gnd_short),
        .sink_above_short(sink_above_short), .current_reached_75(current_reached_75),
        .current_below_50(current_below_50),
        .output_overvoltage_limit(output_overvoltage_limit),
        .ovp_sense_below_20(ovp_sense_below_20),
        .switch_node_above_probe(switch_node_above_probe));

    // ==========================================================
    // clock and hang guard
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    // ==========================================================
    // shared tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    // counts cycles until a channel latches off, bounded
    task automatic time_disable(input int ch);
        k = 0;
        while (channel_disabled_ff[ch] !== 1'b1 && k < 200) begin
            @(negedge clock);
            k++;
        end
    endtask : time_disable

    task automatic start_up(input bit with_short);
        gnd_short = with_short;
        enable_pin = 1'b1;
        if (with_short) begin
            repeat (40) @(negedge clock);
            check({6'h0, fault_switch_on_ff, boost_run_ff}, 8'h00);
            check({7'h0, probe_inject_ff}, 8'h01);
            gnd_short = 1'b0;
        end
        k = 0;
        while (fault_switch_on_ff !== 1'b1 && k < 60) begin
            @(negedge clock);
            k++;
        end
        check({7'h0, k >= PROBE}, 8'h01);
        @(negedge clock);
        check({7'h0, active_ff}, 8'h01);
        check({2'h0, sink_enable_ff}, 8'h3F);
        check({7'h0, boost_run_ff}, 8'h01);
    endtask : start_up

    // ==========================================================
    // scenarios
    task automatic short_channels();
        short_cmd = 6'h01;
        time_disable(0);
        check({7'h0, k >= SHORT_COLD && k <= SHORT_COLD + 6}, 8'h01);
        check({2'h0, sink_enable_ff}, 8'h3E);
        short_cmd = 6'h00;
        temp_lower_hot = 1'b1;
        repeat (4) @(negedge clock);
        short_cmd = 6'h02;
        time_disable(1);
        check({7'h0, k >= SHORT_HOT && k <= SHORT_HOT + 6}, 8'h01);
        check({2'h0, channel_disabled_ff}, 8'h03);
        short_cmd = 6'h00;
        temp_lower_hot = 1'b0;
    endtask : short_channels

    task automatic open_channels();
        open_cmd = 6'h04;
        time_disable(2);
        check({7'h0, k >= OPEN_COLD && k <= OPEN_COLD + 6}, 8'h01);
        check({2'h0, sink_enable_ff}, 8'h38);
        temp_lower_hot = 1'b1;
        repeat (4) @(negedge clock);
        open_cmd = 6'h0C;
        time_disable(3);
        check({7'h0, k >= OPEN_HOT && k <= OPEN_HOT + 6}, 8'h01);
        check({2'h0, sink_enable_ff}, 8'h30);
        check({7'h0, boost_run_ff}, 8'h01);
        temp_lower_hot = 1'b0;
        open_cmd = 6'h00;
    endtask : open_channels

    task automatic ground_short();
        gnd_short = 1'b1;
        repeat (8) @(negedge clock);
        check({6'h0, fault_switch_on_ff, boost_run_ff}, 8'h00);
        repeat (30) @(negedge clock);
        check({7'h0, fault_switch_on_ff}, 8'h00);
        gnd_short = 1'b0;
        k = 0;
        while (fault_switch_on_ff !== 1'b1 && k < 40) begin
            @(negedge clock);
            k++;
        end
        check({7'h0, k >= PROBE && k < 40}, 8'h01);
        repeat (6) @(negedge clock);
        check({7'h0, fault_switch_on_ff}, 8'h01);
    endtask : ground_short

    task automatic enable_off();
        enable_pin = 1'b0;
        repeat (8) @(negedge clock);
        check({6'h0, active_ff, fault_switch_on_ff}, 8'h00);
        check({2'h0, channel_disabled_ff}, 8'h00);
        check({1'h0, current_level_ff}, 8'h64);
    endtask : enable_off

    task automatic thermal_steps();
        logic [6:0] lvl [4];
        logic [1:0] code [4];
        lvl = '{7'h4D, 7'h35, 7'h1E, 7'h1E};
        code = '{2'h1, 2'h2, 2'h3, 2'h3};
        for (int i = 0; i < 4; i++) begin
            temp_upper_hot = 1'b1;
            k = 0;
            while (boost_run_ff !== 1'b0 && k < 10) begin
                @(negedge clock);
                k++;
            end
            repeat (2) @(negedge clock);
            check({2'h0, sink_enable_ff}, 8'h00);
            check({6'h0, active_ff, fault_switch_on_ff}, 8'h03);
            check({6'h0, step_code_ff}, {6'h0, code[i]});
            check({1'h0, current_level_ff}, {1'h0, lvl[i]});
            temp_upper_hot = 1'b0;
            temp_cooled = 1'b1;
            k = 0;
            while (boost_run_ff !== 1'b1 && k < 10) begin
                @(negedge clock);
                k++;
            end
            check({7'h0, boost_run_ff}, 8'h01);
            check({2'h0, sink_enable_ff}, 8'h3F);
            temp_cooled = 1'b0;
            repeat (4) @(negedge clock);
        end
    endtask : thermal_steps

    // ==========================================================
    // main sequence
    initial begin
        reset = 1'b1;
        clk_en = 1'b1;
        enable_pin = 1'b0;
        gnd_short = 1'b0;
        temp_lower_hot = 1'b0;
        temp_upper_hot = 1'b0;
        temp_cooled = 1'b0;
        short_cmd = 6'h00;
        open_cmd = 6'h00;
        n_mismatch = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (12) @(negedge clock);
        reset = 1'b0;
        @(negedge clock);
        check({1'h0, current_level_ff}, 8'h64);
        check({6'h0, active_ff, boost_run_ff}, 8'h00);
        start_up(1'b1);
        short_channels();
        open_channels();
        ground_short();
        enable_off();
        start_up(1'b0);
        thermal_steps();
        end_of_test();
    end
endmodule : led_fault_supervisor_tb
`default_nettype wire
